// ---- rtl/capture_noise_filter.sv ----
// Capture input noise filter requiring successive agreeing samples
`timescale 1ns/1ps
`default_nettype none
module capture_noise_filter #(
  parameter int SAMPLES = timer0_pkg::FILTER_SAMPLES
) (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic rawIn,
  output logic      filteredOut
);
  logic [SAMPLES-2:0] history;
  logic [SAMPLES-2:0] next_history;
  logic               next_filteredOut;

  // Current sample plus stored ones must agree; keeps the added delay at SAMPLES cycles
  always_comb begin
    next_history = {history[SAMPLES-3:0], rawIn};
    next_filteredOut = filteredOut;
    if (&{history, rawIn}) begin
      next_filteredOut = 1'b1; // see R3
    end else if (~|{history, rawIn}) begin
      next_filteredOut = 1'b0; // see R3
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      history     <= '0;
      filteredOut <= 1'b0;
    end else begin
      history     <= next_history;
      filteredOut <= next_filteredOut;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/edge_detect.sv ----
// Selectable-polarity edge detector producing a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic level,
  input  wire logic risingSel,
  output logic      pulse
);
  logic previous;

  // Falling edge when select is zero, rising when one
  assign pulse = risingSel ? (level & ~previous) : (~level & previous); // see R5

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      previous <= 1'b0;
    end else begin
      previous <= level;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/timer0_pkg.sv ----
// Shared constants for the 8/16-bit timer with input capture
package timer0_pkg;
  // Register addresses on the 8-bit register port (chosen)
  localparam logic [2:0] ADDR_CONTROL_A    = 3'h0;
  localparam logic [2:0] ADDR_COUNTER_LOW  = 3'h1;
  localparam logic [2:0] ADDR_COUNTER_HIGH = 3'h2;
  localparam logic [2:0] ADDR_COMPARE_A    = 3'h3;
  localparam logic [2:0] ADDR_COMPARE_B    = 3'h4;
  localparam logic [2:0] ADDR_IRQ_MASK     = 3'h5;
  localparam logic [2:0] ADDR_IRQ_FLAG     = 3'h6;
  // Control register A field positions
  localparam int BIT_WIDTH_SELECT   = 7;
  localparam int BIT_CAPTURE_MODE   = 6;
  localparam int BIT_NOISE_FILTER   = 5;
  localparam int BIT_EDGE_SELECT    = 4;
  localparam int BIT_COMPARATOR_CAP = 3;
  localparam int BIT_CLEAR_ON_MATCH = 0;
  // Writable bits of control register A; bits 2:1 are reserved
  localparam logic [7:0] CONTROL_A_WMASK = 8'hF9;
  localparam logic [7:0] CONTROL_A_RESET = 8'h00;
  // Interrupt mask and flag field position
  localparam int BIT_CAPTURE_IRQ    = 0;
  // Noise filter agreement count
  localparam int FILTER_SAMPLES     = 4;
endpackage

// ---- rtl/timer0_width_capture_config.sv ----
// Timer core: control register A, 16-bit access path and input capture
// Function
// R1: Width bit one gives 16-bit counter and compare
// R2: Capture-enable bit selects input capture mode
// R3: Filter changes after four agreeing samples
// R4: Filter delays capture by four cycles
// R5: Edge select zero falling, one rising
// R6: Capture copies counter and sets flag
// R7: Comparator capture routes comparator through front end
// R8: Comparator ignored when that bit is zero
// R9: Capture interrupt needs mask enable bit
// R10: Bits two and one read zero
// R11: Mode bit picks free-run or clear-on-match; the code clears only in 8-bit mode, 16-bit mode always free-runs
// R12: Software guards two-byte accesses from interrupts
// R13: Temporary high byte survives low-byte write
// R14: Low-byte write commits temp plus low
// R15: Low-byte read loads temp with high
// R16: Write high first, read low first
// R17: 16-bit capture register read through temp
// R18: Control register A resets to zero
`timescale 1ns/1ps
`default_nettype none
module timer0_width_capture_config (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic [2:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regWriteData,
  output logic      [7:0] regReadData,
  input  wire logic       countTick,
  input  wire logic       capture_input_pin,
  input  wire logic       comparatorOut,
  output logic            captureIrq,
  output logic            compareMatch
);
  logic [7:0]  timer_control_a;
  logic [7:0]  timer_irq_mask;
  logic        capture_flag;
  logic [7:0]  tempHigh;
  logic [15:0] counter;
  logic [7:0]  compare_reg_a;
  logic [7:0]  compare_reg_b;
  logic [7:0]  next_control;
  logic [7:0]  next_mask;
  logic        next_flag;
  logic [7:0]  next_temp;
  logic [15:0] next_counter;
  logic [7:0]  next_cmpA;
  logic [7:0]  next_cmpB;
  logic [7:0]  next_readData;
  logic        next_irq;
  logic        next_match;
  logic        pinSync1;
  logic        pinSync2;
  logic        cmpSync1;
  logic        cmpSync2;
  logic        captureSource;
  logic        filtered;
  logic        frontEnd;
  logic        captureEvent;
  logic        wide;
  logic        captureMode;
  logic        clearOnMatch;
  logic [15:0] compareValue;
  logic        matchNow;
  logic        wrLow;
  logic        rdLow;

  assign wide         = timer_control_a[timer0_pkg::BIT_WIDTH_SELECT];   // see R1
  assign captureMode  = timer_control_a[timer0_pkg::BIT_CAPTURE_MODE];   // see R2
  assign clearOnMatch = timer_control_a[timer0_pkg::BIT_CLEAR_ON_MATCH]; // see R11

  // Two-stage synchronisers for the pin and the comparator
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinSync1 <= 1'b0;
      pinSync2 <= 1'b0;
      cmpSync1 <= 1'b0;
      cmpSync2 <= 1'b0;
    end else begin
      pinSync1 <= capture_input_pin;
      pinSync2 <= pinSync1;
      cmpSync1 <= comparatorOut;
      cmpSync2 <= cmpSync1;
    end
  end

  // Comparator replaces the pin only when selected
  assign captureSource = timer_control_a[timer0_pkg::BIT_COMPARATOR_CAP] ? cmpSync2 : pinSync2; // see R7, see R8

  capture_noise_filter #(
    .SAMPLES(timer0_pkg::FILTER_SAMPLES)
  ) u_filter (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .rawIn      (captureSource),
    .filteredOut(filtered)
  );

  // Filtered path costs four extra cycles of latency
  assign frontEnd = timer_control_a[timer0_pkg::BIT_NOISE_FILTER] ? filtered : captureSource; // see R4

  edge_detect u_edge (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .level    (frontEnd),
    .risingSel(timer_control_a[timer0_pkg::BIT_EDGE_SELECT]),
    .pulse    (captureEvent)
  );

  // Compare value: A alone in 8-bit mode, B:A joined in 16-bit mode
  assign compareValue = wide ? {compare_reg_b, compare_reg_a} : {8'h00, compare_reg_a}; // see R1
  assign matchNow = !captureMode && (wide ? (counter == compareValue)
                                          : (counter[7:0] == compare_reg_a));
  assign wrLow = regWrite && (regAddr == timer0_pkg::ADDR_COUNTER_LOW
                           || regAddr == timer0_pkg::ADDR_COMPARE_A);
  assign rdLow = regRead && (regAddr == timer0_pkg::ADDR_COUNTER_LOW
                          || regAddr == timer0_pkg::ADDR_COMPARE_A);

  // Next-state logic for registers, counter and read path
  always_comb begin
    next_control  = timer_control_a;
    next_mask     = timer_irq_mask;
    next_flag     = capture_flag;
    next_temp     = tempHigh;
    next_counter  = counter;
    next_cmpA     = compare_reg_a;
    next_cmpB     = compare_reg_b;
    next_readData = regReadData;
    // Counter advance; clear on match only in 8-bit clear mode
    if (countTick) begin
      if (!wide && !captureMode && clearOnMatch && counter[7:0] == compare_reg_a) begin
        next_counter = 16'h0000; // see R11
      end else if (wide) begin
        next_counter = counter + 16'h0001; // see R1
      end else begin
        next_counter = {8'h00, counter[7:0] + 8'h01}; // see R11
      end
    end
    // Capture copies the count into compare A, and into B:A joined in 16-bit mode
    if (captureMode && captureEvent) begin
      next_cmpA = counter[7:0]; // see R6
      if (wide) begin
        next_cmpB = counter[15:8];
      end
    end
    // Register writes; in 16-bit mode a low-byte write commits temp, temp is kept
    if (regWrite) begin
      case (regAddr)
        timer0_pkg::ADDR_CONTROL_A: begin
          next_control = regWriteData & timer0_pkg::CONTROL_A_WMASK; // see R10
        end
        timer0_pkg::ADDR_COUNTER_LOW: begin
          next_counter = wide ? {tempHigh, regWriteData} : {8'h00, regWriteData}; // see R14, see R13
        end
        timer0_pkg::ADDR_COUNTER_HIGH: begin
          next_temp = regWriteData; // see R16
        end
        timer0_pkg::ADDR_COMPARE_A: begin
          next_cmpA = regWriteData;
          if (wide) begin
            next_cmpB = tempHigh; // see R14, see R13
          end
        end
        timer0_pkg::ADDR_COMPARE_B: begin
          if (wide) begin
            next_temp = regWriteData;
          end else begin
            next_cmpB = regWriteData;
          end
        end
        timer0_pkg::ADDR_IRQ_MASK: begin
          next_mask = {7'h00, regWriteData[timer0_pkg::BIT_CAPTURE_IRQ]};
        end
        timer0_pkg::ADDR_IRQ_FLAG: begin
          if (regWriteData[timer0_pkg::BIT_CAPTURE_IRQ]) begin
            next_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    if (captureMode && captureEvent) begin
      next_flag = 1'b1; // see R6
    end
    // Read path; in 16-bit mode a low-byte read snapshots the high byte into temp
    next_readData = 8'h00;
    if (regRead) begin
      case (regAddr)
        timer0_pkg::ADDR_CONTROL_A:    next_readData = timer_control_a; // see R10
        timer0_pkg::ADDR_COUNTER_LOW:  next_readData = counter[7:0];
        timer0_pkg::ADDR_COUNTER_HIGH: next_readData = wide ? tempHigh : counter[15:8];
        timer0_pkg::ADDR_COMPARE_A:    next_readData = compare_reg_a;
        // Compare B reads through temp only for a 16-bit capture
        timer0_pkg::ADDR_COMPARE_B:    next_readData = (wide && captureMode) ? tempHigh : compare_reg_b; // see R17
        timer0_pkg::ADDR_IRQ_MASK:     next_readData = timer_irq_mask;
        timer0_pkg::ADDR_IRQ_FLAG:     next_readData = {7'h00, capture_flag};
        default:                       next_readData = 8'h00;
      endcase
      if (rdLow && wide) begin
        next_temp = (regAddr == timer0_pkg::ADDR_COUNTER_LOW) ? counter[15:8] : compare_reg_b; // see R15, see R17
      end
    end
    next_irq   = next_flag && next_mask[timer0_pkg::BIT_CAPTURE_IRQ]; // see R9
    next_match = matchNow && countTick && !wrLow;
  end

  // Registered state; control resets to 8-bit normal mode
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_control_a <= timer0_pkg::CONTROL_A_RESET; // see R18
      timer_irq_mask  <= 8'h00;
      capture_flag    <= 1'b0;
      tempHigh        <= 8'h00;
      counter         <= 16'h0000;
      compare_reg_a   <= 8'h00;
      compare_reg_b   <= 8'h00;
      regReadData     <= 8'h00;
      captureIrq      <= 1'b0;
      compareMatch    <= 1'b0;
    end else begin
      timer_control_a <= next_control;
      timer_irq_mask  <= next_mask;
      capture_flag    <= next_flag;
      tempHigh        <= next_temp;
      counter         <= next_counter;
      compare_reg_a   <= next_cmpA;
      compare_reg_b   <= next_cmpB;
      regReadData     <= next_readData;
      captureIrq      <= next_irq;
      compareMatch    <= next_match;
    end
  end
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the timer control and capture block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        sys_clk, sys_rst, regWrite, regRead, countTick, capture_input_pin, comparatorOut;
  logic [2:0]  regAddr;
  logic [7:0]  regWriteData, regReadData, r;
  logic        captureIrq, compareMatch;
  logic [31:0] seed = 32'h65927A6C;
  int          n_errors, checked, cnt, m, k, lat[2];
  timer0_width_capture_config u_timer0_width_capture_config (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData),
    .regReadData(regReadData), .countTick(countTick), .capture_input_pin(capture_input_pin),
    .comparatorOut(comparatorOut), .captureIrq(captureIrq), .compareMatch(compareMatch));
  // Free-running 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes last one cycle and drop at the next edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 cmp(regReadData, e);
  endtask
  task automatic drv(input logic c, input logic v);
    @(posedge sys_clk);
    if (c) comparatorOut <= v;
    else capture_input_pin <= v;
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d of %0d checks", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog, far beyond the expected run of under seven hundred cycles
  initial begin
    repeat (8000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    {regWrite, regRead, countTick, capture_input_pin, comparatorOut, regAddr, regWriteData} = '0;
    n_errors = 0;
    checked = 0;
    sys_rst = 1'b1;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(3'h0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = (i == 0) ? 8'hFF : 8'(rnd());
      wr(3'h0, r);
      rd(3'h0, r & timer0_pkg::CONTROL_A_WMASK);
    end
    // Free-run wraps to 00, clear-on-match restarts after FC
    for (m = 0; m < 2; m++) begin
      wr(3'h0, 8'(m));
      wr(3'h3, 8'hFC);
      wr(3'h1, 8'hFA);
      cnt = 0;
      for (k = 0; k < 8; k++) begin
        @(posedge sys_clk);
        countTick <= (k < 6);
        #1 cnt += int'(compareMatch === 1'b1);
      end
      cmp(8'(cnt), 8'h01);
      rd(3'h1, (m == 1) ? 8'h03 : 8'h00);
    end
    // 16-bit mode, one high byte shared by two registers
    wr(3'h0, 8'h80);
    r = 8'(rnd());
    wr(3'h2, r);
    wr(3'h1, 8'hF0);
    wr(3'h3, 8'h5A);
    cnt = {r, 8'hF0};
    for (k = 0; k < 40; k++) begin
      @(posedge sys_clk);
      m = rnd();
      countTick <= m[0];
      cnt += m & 1;
    end
    @(posedge sys_clk);
    countTick <= 1'b0;
    rd(3'h1, 8'(cnt));
    rd(3'h2, 8'(cnt >> 8));
    rd(3'h4, r);
    rd(3'h3, 8'h5A);
    // Capture over edge, filter and source; bit0 edge, bit1 filter, bit2 comparator
    wr(3'h5, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(3'h0, {2'b11, i[1], i[0], i[2], 3'b000});
      @(posedge sys_clk);
      capture_input_pin <= !i[0];
      comparatorOut <= !i[0];
      repeat (12) @(posedge sys_clk);
      wr(3'h6, 8'h01);
      // New count each pass so a missed capture shows up
      wr(3'h2, 8'(i * 3));
      wr(3'h1, 8'(i + 7));
      cnt = int'({8'(i * 3), 8'(i + 7)});
      drv(!i[2], i[0]);
      repeat (12) @(posedge sys_clk);
      #1 cmp(8'(captureIrq), 8'h00);
      if (i[1]) begin
        drv(i[2], i[0]);
        repeat (2) @(posedge sys_clk);
        drv(i[2], !i[0]);
        repeat (12) @(posedge sys_clk);
        #1 cmp(8'(captureIrq), 8'h00);
      end
      drv(i[2], i[0]);
      for (k = 0; k < 30 && captureIrq !== 1'b1; k++) begin
        @(posedge sys_clk);
        #1;
      end
      lat[i[1]] = k;
      cmp(8'(captureIrq), 8'h01);
      if (i[1]) cmp(8'(lat[1]), 8'(lat[0] + 4));
      rd(3'h3, 8'(cnt));
      rd(3'h4, 8'(cnt >> 8));
      wr(3'h6, 8'h01);
      drv(i[2], !i[0]);
      repeat (12) @(posedge sys_clk);
      #1 cmp(8'(captureIrq), 8'h00);
    end
    // Masked capture stays silent until the mask is set
    wr(3'h5, 8'h00);
    drv(1'b1, 1'b1);
    repeat (12) @(posedge sys_clk);
    #1 cmp(8'(captureIrq), 8'h00);
    wr(3'h5, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1 cmp(8'(captureIrq), 8'h01);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ---- test/timer0_width_capture_config_properties.sv ----
// Port-level assertions for the timer control and capture block
`timescale 1ns/1ps
`default_nettype none
module timer0_width_capture_config_properties (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic [2:0] regAddr,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  input wire logic       countTick,
  input wire logic       capture_input_pin,
  input wire logic       comparatorOut,
  input wire logic       captureIrq,
  input wire logic       compareMatch
);
  logic [7:0] ctrl;
  logic       mask;
  int         quiet;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Shadows of writable bits; quiet restarts on writes, which may legally raise the irq
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl  <= timer0_pkg::CONTROL_A_RESET;
      mask  <= 1'b0;
      quiet <= 0;
    end else begin
      if (regWrite && regAddr == 3'h0) ctrl <= regWriteData & timer0_pkg::CONTROL_A_WMASK;
      if (regWrite && regAddr == 3'h5) mask <= regWriteData[0];
      quiet <= ($changed(capture_input_pin) || $changed(comparatorOut) || regWrite) ? 0 :
               ((quiet < 99) ? quiet + 1 : quiet);
    end
  end
  // Control read and mask-clear write request steps
  sequence s_ctrl_read;
    regRead && regAddr == 3'h0;
  endsequence
  sequence s_mask_off;
    regWrite && regAddr == 3'h5 && !regWriteData[0];
  endsequence
  a_read_idle_zero: assert property (!$past(regRead) |-> regReadData == 8'h00)
    else $error("read data not zero without a read");
  a_ctrl_readback: assert property (s_ctrl_read |=> regReadData == $past(ctrl))
    else $error("control readback differs from writable bits");
  a_mask_readback: assert property (regRead && regAddr == 3'h5 |=> regReadData[0] == $past(mask))
    else $error("mask bit readback wrong");
  a_irq_needs_mask: assert property (captureIrq |-> mask)
    else $error("capture irq without mask bit");
  a_irq_mask_off: assert property (s_mask_off |-> ##2 !captureIrq)
    else $error("capture irq stays after mask cleared");
  a_irq_has_cause: assert property ($rose(captureIrq) |-> quiet < 14)
    else $error("capture irq without input edge");
  a_match_on_tick: assert property (compareMatch |-> $past(countTick))
    else $error("compare match without tick");
  a_match_not_capture: assert property (compareMatch |-> !$past(ctrl[6]))
    else $error("compare match in capture mode");
endmodule
bind timer0_width_capture_config timer0_width_capture_config_properties u_timer0_width_capture_config_properties (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
  .regWriteData(regWriteData), .regReadData(regReadData), .countTick(countTick),
  .capture_input_pin(capture_input_pin), .comparatorOut(comparatorOut), .captureIrq(captureIrq),
  .compareMatch(compareMatch));
`default_nettype wire
